// ==== src/psg_pkg.sv ====
// constants shared by both ends of the sound generator link
// assumes one 20 MHz core clock on both ends
package psg_pkg;
    localparam int PSG_CLK_HZ = 20_000_000;
    localparam int PSG_REF_HZ = 2_000_000;
    localparam int PSG_REF_DIV = PSG_CLK_HZ / PSG_REF_HZ;
    localparam logic [3:0] PSG_REF_LAST = 4'(PSG_REF_DIV - 1);
    localparam logic [3:0] PSG_TONE_PRE_LAST = 4'hF;
    localparam logic [2:0] PSG_SEL_NOISE = 3'h6;
    localparam logic [2:0] PSG_SEL_NOISE_LVL = 3'h7;
    localparam int PSG_FIRST_BIT = 7;
    localparam int PSG_FB_BIT = 2;
    localparam logic [1:0] PSG_RATE_512 = 2'h0;
    localparam logic [1:0] PSG_RATE_1024 = 2'h1;
    localparam logic [1:0] PSG_RATE_2048 = 2'h2;
    localparam logic [1:0] PSG_RATE_TONE3 = 2'h3;
    localparam logic [3:0] PSG_LEVEL_RST = 4'hF;
    localparam logic [9:0] PSG_PERIOD_RST = 10'h000;
    localparam logic [2:0] PSG_NCTL_RST = 3'h0;
    localparam logic [14:0] PSG_LFSR_SEED = 15'h4000;
    localparam logic [3:0] PSG_ADDR_CMD = 4'h0;
    localparam logic [3:0] PSG_ADDR_TONE = 4'h4;
    localparam logic [3:0] PSG_ADDR_STAT = 4'h8;
    localparam logic [1:0] PSG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSG_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PSG_IDLE = 2'b00,
        PSG_SEND1 = 2'b01,
        PSG_SEND2 = 2'b10
    } psg_link_st_t;

    // linear amplitude for each 2 dB step; the last code is silence
    function automatic logic [7:0] psg_amp(input logic [3:0] lvl);
        logic [7:0] a;
        a = 8'h00;
        case (lvl)
            4'h0: a = 8'hFF;
            4'h1: a = 8'hCB;
            4'h2: a = 8'hA1;
            4'h3: a = 8'h80;
            4'h4: a = 8'h66;
            4'h5: a = 8'h51;
            4'h6: a = 8'h40;
            4'h7: a = 8'h33;
            4'h8: a = 8'h28;
            4'h9: a = 8'h20;
            4'hA: a = 8'h1A;
            4'hB: a = 8'h14;
            4'hC: a = 8'h10;
            4'hD: a = 8'h0D;
            4'hE: a = 8'h0A;
            default: a = 8'h00;
        endcase
        return a;
    endfunction
endpackage

// ==== src/psg_link_if.sv ====
// byte link between the command host and the sound generator
// assumes both ends share one clock; no crossing needed
`timescale 1ns/1ns
`default_nettype none
interface psg_link_if (
    input wire logic core_clk_i
);
    logic valid;
    logic ready;
    logic [7:0] data;

    modport dev (input valid, input data, output ready);
    modport host (output valid, output data, input ready);
endinterface
`default_nettype wire

// ==== src/psg_device.sv ====
// sound generator: three square tones, one noise source, four attenuators, a mixer
// assumes command bytes arrive on the byte link from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module psg_device
    import psg_pkg::*;
(
    input wire logic core_clk_i, // core clock, 20 MHz
    input wire logic nrst_i, // synchronous reset, active low
    psg_link_if.dev link, // command bytes from the host
    output logic [9:0] sound_o, // mixed unsigned output level
    output logic [3:0] source_o // raw on/off state of tone1..3 and noise
);
    logic [3:0] ref_q, ref_d;
    logic [3:0] pre_q, pre_d;
    logic [10:0] nrate_q, nrate_d;
    logic ref_tick;
    logic tone_tick;

    logic [2:0] sel_q, sel_d;
    logic [9:0] period_q [3];
    logic [9:0] period_d [3];
    logic [3:0] level_q [4];
    logic [3:0] level_d [4];
    logic [2:0] nctl_q, nctl_d;
    logic nseed;
    logic ready_q;
    logic take;

    logic [9:0] cnt_q [3];
    logic [9:0] cnt_d [3];
    logic [2:0] tone_q, tone_d;
    logic tone3_prev_q;
    logic [14:0] lfsr_q, lfsr_d;
    logic shift_en;
    logic [9:0] sound_d;
    logic [3:0] src;

    // reference clock of 2 MHz made as a tick from the core clock
    always_comb begin
        ref_d = (ref_q == PSG_REF_LAST) ? 4'h0 : ref_q + 4'h1;
        pre_d = pre_q;
        nrate_d = nrate_q;
        if (ref_tick) begin
            pre_d = pre_q + 4'h1;
            nrate_d = nrate_q + 11'h001;
        end
    end

    assign ref_tick = (ref_q == PSG_REF_LAST);
    assign tone_tick = ref_tick && (pre_q == PSG_TONE_PRE_LAST);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ref_q <= 4'h0;
            pre_q <= 4'h0;
            nrate_q <= 11'h000;
        end else begin
            ref_q <= ref_d;
            pre_q <= pre_d;
            nrate_q <= nrate_d;
        end
    end

    // command decode; the device never stalls the link after reset
    assign take = link.valid && ready_q;

    always_comb begin
        sel_d = sel_q;
        period_d = period_q;
        level_d = level_q;
        nctl_d = nctl_q;
        nseed = 1'b0;
        if (take) begin
            if (link.data[PSG_FIRST_BIT]) begin
                sel_d = link.data[6:4];
                if (link.data[4]) begin
                    level_d[link.data[6:5]] = link.data[3:0];
                end else if (link.data[6:4] == PSG_SEL_NOISE) begin
                    nctl_d = link.data[2:0];
                    nseed = 1'b1;
                end else begin
                    period_d[link.data[6:5]][3:0] = link.data[3:0];
                end
            end else if (!sel_q[0] && sel_q != PSG_SEL_NOISE) begin
                // a data byte after a level or noise select is dropped
                period_d[sel_q[2:1]][9:4] = link.data[5:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sel_q <= 3'h0;
            nctl_q <= PSG_NCTL_RST;
            ready_q <= 1'b0;
            for (int k = 0; k < 4; k++) begin
                level_q[k] <= PSG_LEVEL_RST;
            end
            for (int k = 0; k < 3; k++) begin
                period_q[k] <= PSG_PERIOD_RST;
            end
        end else begin
            sel_q <= sel_d;
            nctl_q <= nctl_d;
            ready_q <= 1'b1;
            level_q <= level_d;
            period_q <= period_d;
        end
    end

    assign link.ready = ready_q;

    // tone dividers: half a cycle is period ticks of ref/16
    // period 0 behaves like period 1, giving the highest pitch
    for (genvar i = 0; i < 3; i++) begin : g_tone
        always_comb begin
            cnt_d[i] = cnt_q[i];
            tone_d[i] = tone_q[i];
            if (tone_tick) begin
                if (cnt_q[i] <= 10'h001) begin
                    cnt_d[i] = period_q[i];
                    tone_d[i] = ~tone_q[i];
                end else begin
                    cnt_d[i] = cnt_q[i] - 10'h001;
                end
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
                cnt_q[i] <= 10'h000;
                tone_q[i] <= 1'b0;
            end else begin
                cnt_q[i] <= cnt_d[i];
                tone_q[i] <= tone_d[i];
            end
        end
    end

    // noise shift clock selection
    always_comb begin
        shift_en = 1'b0;
        case (nctl_q[1:0])
            PSG_RATE_512: shift_en = ref_tick && (&nrate_q[8:0]);
            PSG_RATE_1024: shift_en = ref_tick && (&nrate_q[9:0]);
            PSG_RATE_2048: shift_en = ref_tick && (&nrate_q[10:0]);
            PSG_RATE_TONE3: shift_en = tone_q[2] && !tone3_prev_q;
            default: shift_en = 1'b0;
        endcase
    end

    always_comb begin
        lfsr_d = lfsr_q;
        if (nseed) begin
            // restarting the register on every noise control write keeps it from sticking at zero
            lfsr_d = PSG_LFSR_SEED;
        end else if (shift_en) begin
            if (nctl_q[PSG_FB_BIT]) begin
                lfsr_d = {lfsr_q[0] ^ lfsr_q[1], lfsr_q[14:1]};
            end else begin
                lfsr_d = {lfsr_q[0], lfsr_q[14:1]};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            lfsr_q <= PSG_LFSR_SEED;
            tone3_prev_q <= 1'b0;
        end else begin
            lfsr_q <= lfsr_d;
            tone3_prev_q <= tone_q[2];
        end
    end

    // mixer: unipolar square waves scaled by their level and summed
    assign src = {lfsr_q[0], tone_q};

    always_comb begin
        sound_d = 10'h000;
        for (int k = 0; k < 4; k++) begin
            if (src[k]) begin
                sound_d = sound_d + {2'b00, psg_amp(level_q[k])};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sound_o <= 10'h000;
            source_o <= 4'h0;
        end else begin
            sound_o <= sound_d;
            source_o <= src;
        end
    end
endmodule
`default_nettype wire

// ==== src/psg_host.sv ====
// command host: AXI4-Lite slave registers turned into sound command bytes
// assumes the device end shares core_clk_i and may stall with ready
`timescale 1ns/1ns
`default_nettype none
module psg_host
    import psg_pkg::*;
(
    input wire logic core_clk_i, // core clock, 20 MHz
    input wire logic nrst_i, // synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes, ignored
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    psg_link_if.host link // command bytes to the device
);
    psg_link_st_t st_q, st_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic valid_q, valid_d;
    logic [7:0] data_q, data_d, second_q, second_d;
    logic two_q, two_d;
    logic [7:0] sent_q, sent_d;
    logic exec;

    // a write is carried out only once the link is idle, so software sees backpressure
    assign exec = aw_have_q && w_have_q && st_q == PSG_IDLE && !bvalid_q;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        st_d = st_q;
        valid_d = valid_q;
        data_d = data_q;
        second_d = second_q;
        two_d = two_q;
        sent_d = sent_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        case (st_q)
            PSG_IDLE: begin
                if (exec) begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = PSG_RESP_OKAY;
                    if (awaddr_q == PSG_ADDR_CMD) begin
                        data_d = wdata_q[7:0];
                        two_d = 1'b0;
                        valid_d = 1'b1;
                        st_d = PSG_SEND1;
                    end else if (awaddr_q == PSG_ADDR_TONE && wdata_q[13:12] != 2'h3) begin
                        data_d = {1'b1, wdata_q[13:12], 1'b0, wdata_q[3:0]};
                        second_d = {2'b00, wdata_q[9:4]};
                        two_d = 1'b1;
                        valid_d = 1'b1;
                        st_d = PSG_SEND1;
                    end else begin
                        bresp_d = PSG_RESP_SLVERR;
                    end
                end
            end
            PSG_SEND1: begin
                if (link.ready) begin
                    sent_d = sent_q + 8'h01;
                    if (two_q) begin
                        data_d = second_q;
                        st_d = PSG_SEND2;
                    end else begin
                        valid_d = 1'b0;
                        st_d = PSG_IDLE;
                    end
                end
            end
            PSG_SEND2: begin
                if (link.ready) begin
                    sent_d = sent_q + 8'h01;
                    valid_d = 1'b0;
                    st_d = PSG_IDLE;
                end
            end
            default: st_d = PSG_IDLE;
        endcase
    end

    always_comb begin
        // comes up by itself on the first edge after reset, when no read is pending
        arready_d = arready_q || !rvalid_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = PSG_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == PSG_ADDR_STAT) begin
                rdata_d = {16'h0000, sent_q, 7'h00, st_q != PSG_IDLE};
            end else if (s_axi_araddr != PSG_ADDR_CMD && s_axi_araddr != PSG_ADDR_TONE) begin
                rresp_d = PSG_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st_q <= PSG_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            bvalid_q <= 1'b0;
            bresp_q <= PSG_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PSG_RESP_OKAY;
            valid_q <= 1'b0;
            data_q <= 8'h00;
            second_q <= 8'h00;
            two_q <= 1'b0;
            sent_q <= 8'h00;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            st_q <= st_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            valid_q <= valid_d;
            data_q <= data_d;
            second_q <= second_d;
            two_q <= two_d;
            sent_q <= sent_d;
            s_axi_awready <= !aw_have_d;
            s_axi_wready <= !w_have_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign link.valid = valid_q;
    assign link.data = data_q;
endmodule
`default_nettype wire

// ==== test/psg_chk.sv ====
// checker on the byte link between host and device, plus the mixed output
// assumes one clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ns
`default_nettype none
module psg_chk (
    input wire logic core_clk_i, // core clock
    input wire logic nrst_i, // reset, active low
    input wire logic valid, // byte offered
    input wire logic ready, // byte can be taken
    input wire logic [7:0] data, // command byte
    input wire logic [9:0] sound_o, // mixed level
    input wire logic [3:0] source_o // raw source states
);
    logic [15:0] gap_q [3];
    logic [15:0] gap_d [3];
    logic [2:0] src_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // cycles since each tone last toggled; saturates so long silences stay harmless
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gap_d[i] = (source_o[i] != src_q[i]) ? 16'h0000 : gap_q[i] + 16'(gap_q[i] != 16'hFFFF);
        end
    end
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            gap_q[i] <= nrst_i ? gap_d[i] : 16'h0000;
        end
        src_q <= nrst_i ? source_o[2:0] : 3'h0;
    end
    property p_ready;
        nrst_i && $past(nrst_i) |-> ready;
    endproperty
    a_ready: assert property (p_ready) else $error("link not ready");
    property p_hold;
        valid && !ready |=> valid && $stable(data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled");
    property p_last;
        valid && ready && !data[7] |=> !valid;
    endproperty
    a_last: assert property (p_last) else $error("byte after a data byte");
    property p_pair;
        valid && ready && data[7] && !data[4] && data[6:5] != 2'b11 ##1 valid |-> !data[7] && !data[6];
    endproperty
    a_pair: assert property (p_pair) else $error("bad second tone byte");
    property p_max;
        sound_o <= 10'h3FC;
    endproperty
    a_max: assert property (p_max) else $error("mix above four full sources");
    property p_quiet;
        source_o == 4'h0 |-> sound_o == 10'h000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("mix not zero with all sources off");
    property p_gap(int i);
        source_o[i] != src_q[i] |-> gap_q[i] >= 16'h0096;
    endproperty
    property p_gap1;
        p_gap(0);
    endproperty
    a_gap1: assert property (p_gap1) else $error("tone1 toggles too fast");
    property p_gap2;
        p_gap(1);
    endproperty
    a_gap2: assert property (p_gap2) else $error("tone2 toggles too fast");
    property p_gap3;
        p_gap(2);
    endproperty
    a_gap3: assert property (p_gap3) else $error("tone3 toggles too fast");
    c_pair: cover property (valid && ready && data[7] ##1 valid && !data[7]);
    c_noise: cover property ($rose(source_o[3]));
    c_loud: cover property (sound_o == 10'h0FF);
endmodule
`default_nettype wire

// ==== test/programmable_sound_generator_tb_top.sv ====
// bench: AXI4-Lite orders into the host end, sound watched at the device end
// assumes both ends meet in psg_link_if on one 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module programmable_sound_generator_tb_top import psg_pkg::*;;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] sound_o;
    logic [3:0] source_o;
    int failures = 0;
    int n_tests = 0;
    psg_link_if psg_link_if_inst (.core_clk_i(core_clk_i));
    psg_host psg_host_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link(psg_link_if_inst));
    psg_device psg_device_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .link(psg_link_if_inst), .sound_o(sound_o), .source_o(source_o));
    psg_chk psg_chk_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .valid(psg_link_if_inst.valid), .ready(psg_link_if_inst.ready),
        .data(psg_link_if_inst.data), .sound_o(sound_o), .source_o(source_o));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(inout int n);
        @(posedge core_clk_i);
        n++;
        if (n > 30000) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask
    // master holds each channel until its own handshake, bready until bvalid
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            step(n);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge core_clk_i);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            step(n);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge core_clk_i);
    endtask
    task automatic cmd(input logic [7:0] b);
        axi_wr(PSG_ADDR_CMD, {24'h0, b}, PSG_RESP_OKAY);
    endtask
    task automatic wait_lvl(input int i, input logic lvl);
        int n;
        n = 0;
        while (source_o[i] !== lvl) step(n);
    endtask
    // cycles that a source stays high after a fresh rising edge
    task automatic high_time(input int i, input int exp);
        int n;
        wait_lvl(i, 1'b0);
        wait_lvl(i, 1'b1);
        n = 0;
        while (source_o[i] === 1'b1) step(n);
        chk(n, exp);
    endtask
    task automatic t_tone1();
        axi_wr(PSG_ADDR_TONE, 32'h0000_0003, PSG_RESP_OKAY);
        axi_rd(PSG_ADDR_STAT, 32'h0000_0200, PSG_RESP_OKAY);
        high_time(0, 3 * 160);
        wait_lvl(0, 1'b1);
        chk({22'h0, sound_o}, 32'h0);
    endtask
    task automatic t_host();
        axi_wr(PSG_ADDR_TONE, 32'h0000_3005, PSG_RESP_SLVERR);
        axi_wr(4'hC, 32'h0, PSG_RESP_SLVERR);
        axi_rd(4'hC, 32'h0, PSG_RESP_SLVERR);
        axi_rd(PSG_ADDR_CMD, 32'h0, PSG_RESP_OKAY);
        axi_rd(PSG_ADDR_STAT, 32'h0000_0200, PSG_RESP_OKAY);
    endtask
    task automatic t_levels();
        logic [3:0] lv [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
        logic [7:0] amp [4] = '{8'hFF, 8'hCB, 8'h0A, 8'h00};
        for (int k = 0; k < 4; k++) begin
            cmd({4'h9, lv[k]});
            wait_lvl(0, 1'b0);
            wait_lvl(0, 1'b1);
            repeat (4) @(posedge core_clk_i);
            chk({22'h0, sound_o}, {24'h0, amp[k]});
        end
    endtask
    // stray data byte after a level select must not reach the tone2 period
    task automatic t_tone2();
        cmd(8'hA2);
        cmd(8'h00);
        cmd(8'h01);
        cmd(8'hB0);
        cmd(8'h3F);
        high_time(1, 18 * 160);
    endtask
    // tone3 at period 1 clocks the noise every 320 cycles; seed gives one
    // bit high per 15 shifts when rotating, two adjacent highs when white
    task automatic t_noise();
        axi_wr(PSG_ADDR_TONE, 32'h0000_2001, PSG_RESP_OKAY);
        cmd(8'hE3);
        high_time(3, 320);
        high_time(3, 320);
        cmd(8'hE7);
        high_time(3, 320);
        high_time(3, 640);
        // tone2 still sounds from the earlier scenario; mute it so only noise is mixed
        cmd(8'hBF);
        cmd(8'hF0);
        wait_lvl(3, 1'b1);
        repeat (2) @(posedge core_clk_i);
        chk({22'h0, sound_o}, 32'h0000_00FF);
    endtask
    task automatic t_rates();
        int hi;
        for (int r = 0; r < 3; r++) begin
            cmd({6'b111001, 2'(r)});
            hi = 0;
            repeat (5000) begin
                @(posedge core_clk_i);
                hi += (source_o[3] !== 1'b0);
            end
            chk(hi, 0);
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        t_tone1();
        t_host();
        t_levels();
        t_tone2();
        t_noise();
        t_rates();
        end_sim();
    end
endmodule
`default_nettype wire
